// ---- common/frame_pkg.sv ----
// Package with constants, types and register map of the timing report packet framer
package frame_pkg;
    // --------------------------------------------------------------
    // Frame layout
    // --------------------------------------------------------------
    localparam logic [7:0] DLE_BYTE = 8'h10;
    localparam logic [7:0] ETX_BYTE = 8'h03;
    localparam logic [7:0] MSG_ID = 8'hA1;
    localparam logic [7:0] SUB_CORR = 8'h02;
    localparam logic [7:0] SUB_FREQ = 8'h03;
    localparam logic [7:0] MODE_QUERY = 8'h00;
    localparam logic [7:0] MODE_RESP = 8'h02;
    localparam logic [15:0] QUERY_LEN = 16'h0002;
    localparam logic [3:0] QUERY_LAST = 4'h8;
    localparam logic [5:0] CORR_CKS_POS = 6'd33;
    localparam logic [5:0] FREQ_CKS_POS = 6'd53;
    localparam logic [5:0] FIRST_LEN_POS = 6'd5;
    localparam logic [5:0] FREQ_LOOP_POS = 6'd19;
    localparam logic [5:0] FREQ_REF_POS = 6'd52;
    localparam logic [31:0] TIME_OF_WEEK_MAX = 32'h00093A7F;
    localparam logic [7:0] DAC_BITS_MAX = 8'h20;
    localparam logic [7:0] LOOP_STATE_MAX = 8'h09;
    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int REPORT_PERIOD_MS = 1000;
    localparam int REPORT_CYCLES = REPORT_PERIOD_MS * 1000000 / CLK_PERIOD_NS;
    // --------------------------------------------------------------
    // Register offsets and reset values
    // --------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_VALID = 8'h08;
    localparam logic [7:0] REG_WEEK = 8'h0C;
    localparam logic [7:0] REG_TIME_OF_WEEK = 8'h10;
    localparam logic [7:0] REG_OFS1 = 8'h14;
    localparam logic [7:0] REG_OFS4 = 8'h20;
    localparam logic [7:0] REG_FREQ = 8'h24;
    localparam logic [7:0] REG_OSC = 8'h28;
    localparam int CTRL_PERIODIC_BIT = 0;
    localparam int CTRL_MULTI_BIT = 1;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_t;
    typedef enum logic [0:0] {RX_HUNT = 1'b0, RX_BODY = 1'b1} rx_state_t;
    typedef enum logic [0:0] {TX_IDLE = 1'b0, TX_SEND = 1'b1} tx_state_t;
endpackage : frame_pkg

// ---- hdl/report_framer.sv ----
// Timing report packet framer: query parser, response builder and APB register file
//
// Added by the designer: the APB slave port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - Length field counts mode, data and checksum bytes together.
// - Correction response byte 6 holds valid flags; bit 0 is the reference itself.
// - Correction response bytes 7-8 carry the week number.
// - Bytes 9-12 carry time of week, kept within 0 to 604799.
// - Bytes 13-16 carry a reference-to-reference offset, always zero.
// - Bytes 17-32 carry four constellation offsets in valid-flag order.
// - Correction response ends with checksum at 33, then 0x10, 0x03.
// - Query for subidentifier 0x03 gets a frequency response with mode 2.
// - With periodic output enabled, the frequency response goes out every second.
// - Bytes 6-9 carry the oscillator frequency offset.
// - Byte 10 carries converter resolution, 0 to 32 bits.
// - Converter size zero marks synthesis steering; offset field is the control.
// - Byte 52 carries the configured reference input selection.
// - Corrections are answered only when extra constellations are enabled.
// - Byte 19 carries loop state 0 to 9.
module report_framer import frame_pkg::*; #(
    parameter int PERIOD_CYCLES = REPORT_CYCLES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Query byte stream in
    input wire byte_beat_t rx_beat,
    // Response byte stream out
    output byte_beat_t tx_beat,
    input wire logic tx_ready
);
    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [1:0] ctrl_r, ctrl_nxt;
    logic [4:0] valid_r, valid_nxt;
    logic [15:0] week_r, week_nxt;
    logic [31:0] time_of_week_seconds_r, time_of_week_seconds_nxt;
    logic [31:0] ofs_r [4];
    logic [31:0] ofs_nxt [4];
    logic [31:0] freq_r, freq_nxt;
    logic [23:0] osc_r, osc_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
    logic [15:0] drop_cnt_r, drop_cnt_nxt;
    logic tx_busy;
    logic drop_evt;
    logic bus_commit;

    assign bus_commit = psel & penable & pready_r;

    // Decode reads and writes; answer one wait state after setup
    always_comb begin
        ctrl_nxt = ctrl_r;
        valid_nxt = valid_r;
        week_nxt = week_r;
        time_of_week_seconds_nxt = time_of_week_seconds_r;
        ofs_nxt = ofs_r;
        freq_nxt = freq_r;
        osc_nxt = osc_r;
        prdata_nxt = prdata_r;
        pslverr_nxt = 1'b0;
        pready_nxt = psel & penable & ~pready_r;
        if (psel && penable && !pready_r) begin
            prdata_nxt = RST_ZERO;
            case (paddr)
                REG_CTRL: prdata_nxt = {30'h0, ctrl_r};
                REG_STATUS: prdata_nxt = {drop_cnt_r, 15'h0, tx_busy};
                REG_VALID: prdata_nxt = {27'h0, valid_r};
                REG_WEEK: prdata_nxt = {16'h0, week_r};
                REG_TIME_OF_WEEK: prdata_nxt = time_of_week_seconds_r;
                REG_FREQ: prdata_nxt = freq_r;
                REG_OSC: prdata_nxt = {8'h0, osc_r};
                default: begin
                    if (paddr >= REG_OFS1 && paddr <= REG_OFS4 && paddr[1:0] == 2'b00) begin
                        prdata_nxt = ofs_r[paddr[3:2] - 2'd1];
                    end else begin
                        pslverr_nxt = 1'b1;
                    end
                end
            endcase
            if (pwrite) begin
                prdata_nxt = RST_ZERO;
            end
        end
        if (bus_commit && pwrite && !pslverr_r) begin
            case (paddr)
                REG_CTRL: ctrl_nxt = pwdata[1:0];
                REG_VALID: valid_nxt = pwdata[4:0];
                REG_WEEK: week_nxt = pwdata[15:0];
                REG_TIME_OF_WEEK: begin
                    time_of_week_seconds_nxt = (pwdata > TIME_OF_WEEK_MAX) ? TIME_OF_WEEK_MAX : pwdata;
                end
                REG_FREQ: freq_nxt = pwdata;
                REG_OSC: begin
                    osc_nxt[7:0] = (pwdata[7:0] > DAC_BITS_MAX) ? DAC_BITS_MAX : pwdata[7:0];
                    osc_nxt[15:8] = (pwdata[15:8] > LOOP_STATE_MAX) ? 8'h00 : pwdata[15:8];
                    osc_nxt[23:16] = pwdata[23:16];
                end
                default: begin
                    if (paddr >= REG_OFS1 && paddr <= REG_OFS4) begin
                        ofs_nxt[paddr[3:2] - 2'd1] = pwdata;
                    end
                end
            endcase
        end
        drop_cnt_nxt = drop_cnt_r + {15'h0, drop_evt};
    end

    // Register stage of the register file
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 2'b00;
            valid_r <= 5'h00;
            week_r <= 16'h0000;
            time_of_week_seconds_r <= RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                ofs_r[i] <= RST_ZERO;
            end
            freq_r <= RST_ZERO;
            osc_r <= 24'h000000;
            prdata_r <= RST_ZERO;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            drop_cnt_r <= 16'h0000;
        end else begin
            ctrl_r <= ctrl_nxt;
            valid_r <= valid_nxt;
            week_r <= week_nxt;
            time_of_week_seconds_r <= time_of_week_seconds_nxt;
            ofs_r <= ofs_nxt;
            freq_r <= freq_nxt;
            osc_r <= osc_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
            drop_cnt_r <= drop_cnt_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ------------------------------------------------------------------
    // Query parser
    // ------------------------------------------------------------------
    rx_state_t rx_state_r, rx_state_nxt;
    logic [3:0] rx_idx_r, rx_idx_nxt;
    logic [7:0] rx_sub_r, rx_sub_nxt;
    logic rx_ok_r, rx_ok_nxt;
    logic corr_req, freq_req;

    // Every query is nine bytes; each fixed byte is checked as it lands and the verdict
    // falls on the last trailer byte. The checksum is carried but not judged.
    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_idx_nxt = rx_idx_r;
        rx_sub_nxt = rx_sub_r;
        rx_ok_nxt = rx_ok_r;
        corr_req = 1'b0;
        freq_req = 1'b0;
        drop_evt = 1'b0;
        if (rx_beat.valid) begin
            case (rx_state_r)
                RX_HUNT: begin
                    if (rx_beat.data == DLE_BYTE) begin
                        rx_state_nxt = RX_BODY;
                        rx_idx_nxt = 4'h1;
                        rx_ok_nxt = 1'b1;
                    end
                end
                RX_BODY: begin
                    rx_idx_nxt = rx_idx_r + 4'h1;
                    case (rx_idx_r)
                        4'h1: rx_ok_nxt = rx_ok_r & (rx_beat.data == MSG_ID);
                        4'h2: rx_sub_nxt = rx_beat.data;
                        4'h3: rx_ok_nxt = rx_ok_r & (rx_beat.data == QUERY_LEN[15:8]);
                        4'h4: rx_ok_nxt = rx_ok_r & (rx_beat.data == QUERY_LEN[7:0]);
                        4'h5: rx_ok_nxt = rx_ok_r & (rx_beat.data == MODE_QUERY);
                        4'h7: rx_ok_nxt = rx_ok_r & (rx_beat.data == DLE_BYTE);
                        default: rx_ok_nxt = rx_ok_r;
                    endcase
                    if (rx_idx_r == QUERY_LAST) begin
                        rx_state_nxt = RX_HUNT;
                        rx_idx_nxt = 4'h0;
                        if (rx_ok_r && rx_beat.data == ETX_BYTE && rx_sub_r == SUB_CORR) begin
                            corr_req = ctrl_r[CTRL_MULTI_BIT];
                            drop_evt = ~ctrl_r[CTRL_MULTI_BIT];
                        end else if (rx_ok_r && rx_beat.data == ETX_BYTE && rx_sub_r == SUB_FREQ) begin
                            freq_req = 1'b1;
                        end else begin
                            drop_evt = 1'b1;
                        end
                    end
                end
                default: rx_state_nxt = RX_HUNT;
            endcase
        end
    end

    // Register stage of the parser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state_r <= RX_HUNT;
            rx_idx_r <= 4'h0;
            rx_sub_r <= 8'h00;
            rx_ok_r <= 1'b0;
        end else begin
            rx_state_r <= rx_state_nxt;
            rx_idx_r <= rx_idx_nxt;
            rx_sub_r <= rx_sub_nxt;
            rx_ok_r <= rx_ok_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Once-a-second tick and pending requests
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt_r, tick_cnt_nxt;
    logic corr_pend_r, corr_pend_nxt, freq_pend_r, freq_pend_nxt;
    logic tick;
    logic start_corr, start_freq;

    // A new request sets its pending flag even in the cycle the flag is served
    always_comb begin
        tick = (tick_cnt_r == 32'(PERIOD_CYCLES - 1));
        tick_cnt_nxt = tick ? 32'h0 : tick_cnt_r + 32'h1;
        corr_pend_nxt = (corr_pend_r & ~start_corr) | corr_req;
        freq_pend_nxt = (freq_pend_r & ~start_freq) | freq_req | (tick & ctrl_r[CTRL_PERIODIC_BIT]);
    end

    // Register stage of tick and pending flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_r <= 32'h0;
            corr_pend_r <= 1'b0;
            freq_pend_r <= 1'b0;
        end else begin
            tick_cnt_r <= tick_cnt_nxt;
            corr_pend_r <= corr_pend_nxt;
            freq_pend_r <= freq_pend_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Response builder
    // ------------------------------------------------------------------
    tx_state_t tx_state_r, tx_state_nxt;
    logic tx_corr_r, tx_corr_nxt;
    logic [5:0] tx_idx_r, tx_idx_nxt;
    logic [7:0] tx_cks_r, tx_cks_nxt;
    byte_beat_t tx_beat_r, tx_beat_nxt;
    logic [7:0] next_byte;
    logic [5:0] next_idx;
    logic next_corr;

    // Byte of a response frame at a given position; fields are sent most significant first
    function automatic logic [7:0] frame_byte(input logic corr, input logic [5:0] idx, input logic [7:0] cks);
        logic [5:0] rel;
        logic [31:0] word;
        rel = idx - 6'd17;
        word = ofs_r[rel[3:2]];
        frame_byte = 8'h00;
        case (idx)
            6'd0: frame_byte = DLE_BYTE;
            6'd1: frame_byte = MSG_ID;
            6'd2: frame_byte = corr ? SUB_CORR : SUB_FREQ;
            6'd3: frame_byte = 8'h00;
            6'd4: frame_byte = 8'(corr ? CORR_CKS_POS - FIRST_LEN_POS + 6'd1 : FREQ_CKS_POS - FIRST_LEN_POS + 6'd1);
            6'd5: frame_byte = MODE_RESP;
            default: begin
                if (corr) begin
                    if (idx == 6'd6) frame_byte = {3'b000, valid_r[4:1], 1'b1};
                    else if (idx == 6'd7) frame_byte = week_r[15:8];
                    else if (idx == 6'd8) frame_byte = week_r[7:0];
                    else if (idx <= 6'd12) frame_byte = time_of_week_seconds_r[8'(6'd12 - idx) * 8 +: 8];
                    else if (idx <= 6'd16) frame_byte = 8'h00;
                    else if (idx < CORR_CKS_POS) frame_byte = word[8'(2'd3 - rel[1:0]) * 8 +: 8];
                    else if (idx == CORR_CKS_POS) frame_byte = cks;
                    else if (idx == CORR_CKS_POS + 6'd1) frame_byte = DLE_BYTE;
                    else frame_byte = ETX_BYTE;
                end else begin
                    if (idx <= 6'd9) frame_byte = freq_r[8'(6'd9 - idx) * 8 +: 8];
                    else if (idx == 6'd10) frame_byte = osc_r[7:0];
                    else if (idx == FREQ_LOOP_POS) frame_byte = osc_r[15:8];
                    else if (idx == FREQ_REF_POS) frame_byte = osc_r[23:16];
                    else if (idx == FREQ_CKS_POS) frame_byte = cks;
                    else if (idx == FREQ_CKS_POS + 6'd1) frame_byte = DLE_BYTE;
                    else if (idx == FREQ_CKS_POS + 6'd2) frame_byte = ETX_BYTE;
                    else frame_byte = 8'h00;
                end
            end
        endcase
    endfunction

    // Corrections win a tie; a frame once started is sent whole
    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_corr_nxt = tx_corr_r;
        tx_idx_nxt = tx_idx_r;
        tx_cks_nxt = tx_cks_r;
        tx_beat_nxt = tx_beat_r;
        start_corr = 1'b0;
        start_freq = 1'b0;
        next_idx = tx_idx_r + 6'd1;
        next_corr = tx_corr_r;
        if (tx_state_r == TX_IDLE) begin
            next_idx = 6'd0;
            next_corr = corr_pend_r;
        end
        next_byte = frame_byte(next_corr, next_idx, tx_cks_r);
        case (tx_state_r)
            TX_IDLE: begin
                if (corr_pend_r || freq_pend_r) begin
                    start_corr = corr_pend_r;
                    start_freq = ~corr_pend_r;
                    tx_state_nxt = TX_SEND;
                    tx_corr_nxt = corr_pend_r;
                    tx_idx_nxt = 6'd0;
                    tx_cks_nxt = 8'h00;
                    tx_beat_nxt = '{valid: 1'b1, data: next_byte};
                end
            end
            TX_SEND: begin
                if (tx_ready) begin
                    if (tx_idx_r != 6'd0) begin
                        tx_cks_nxt = tx_cks_r ^ tx_beat_r.data;
                    end
                    if (tx_idx_r == (tx_corr_r ? CORR_CKS_POS : FREQ_CKS_POS) + 6'd2) begin
                        tx_state_nxt = TX_IDLE;
                        tx_beat_nxt = '{valid: 1'b0, data: 8'h00};
                    end else begin
                        tx_idx_nxt = next_idx;
                        tx_beat_nxt = '{valid: 1'b1,
                            data: frame_byte(tx_corr_r, next_idx, tx_cks_r ^ tx_beat_r.data)};
                    end
                end
            end
            default: tx_state_nxt = TX_IDLE;
        endcase
        tx_busy = (tx_state_r == TX_SEND);
    end

    // Register stage of the builder
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state_r <= TX_IDLE;
            tx_corr_r <= 1'b0;
            tx_idx_r <= 6'd0;
            tx_cks_r <= 8'h00;
            tx_beat_r <= '{valid: 1'b0, data: 8'h00};
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_corr_r <= tx_corr_nxt;
            tx_idx_r <= tx_idx_nxt;
            tx_cks_r <= tx_cks_nxt;
            tx_beat_r <= tx_beat_nxt;
        end
    end

    assign tx_beat = tx_beat_r;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_send(int n);
        tx_beat_r.valid && tx_ready && tx_idx_r == 6'(n);
    endsequence

    a_corr_flag_ref: assert property (s_send(6) ##0 tx_corr_r |-> tx_beat_r.data[0] && tx_beat_r.data[7:5] == 3'b000)
        else $error("reference valid bit missing");
    a_week_time_range: assert property (time_of_week_seconds_r <= TIME_OF_WEEK_MAX)
        else $error("time of week out of range");
    a_ref_ofs_zero: assert property (tx_beat_r.valid && tx_corr_r && tx_idx_r >= 6'd13
            && tx_idx_r <= 6'd16 |-> tx_beat_r.data == 8'h00)
        else $error("reference offset not zero");
    a_corr_trailer: assert property (s_send(34) ##0 tx_corr_r |-> tx_beat_r.data == DLE_BYTE
            ##1 (tx_beat_r.data == ETX_BYTE && tx_idx_r == 6'd35))
        else $error("correction trailer wrong");
    a_len_field: assert property (s_send(4) |-> tx_beat_r.data == (tx_corr_r ? 8'h1D : 8'h31))
        else $error("length field wrong");
    a_freq_answer: assert property (freq_req |=> freq_pend_r)
        else $error("frequency query not taken");
    a_mode_resp: assert property (s_send(5) |-> tx_beat_r.data == MODE_RESP)
        else $error("response mode wrong");
    a_periodic_tick: assert property (tick && ctrl_r[CTRL_PERIODIC_BIT] |=> freq_pend_r)
        else $error("periodic report lost");
    a_dac_range: assert property (osc_r[7:0] <= DAC_BITS_MAX)
        else $error("converter size out of range");
    a_loop_range: assert property (osc_r[15:8] <= LOOP_STATE_MAX)
        else $error("loop state out of range");
    a_corr_gated: assert property (corr_req |-> ctrl_r[CTRL_MULTI_BIT])
        else $error("corrections sent while single constellation");
    // A periodic tick in the drop cycle raises a report on its own, so it is left out
    a_bad_dropped: assert property (drop_evt && !tick |=> !$rose(corr_pend_r) && !$rose(freq_pend_r))
        else $error("bad query answered");
    a_stall_holds: assert property (tx_beat_r.valid && !tx_ready |=> $stable(tx_beat_r))
        else $error("byte changed under stall");
endmodule : report_framer

// ---- testbench/host_model.sv ----
// Host partner: sends query frames, takes response bytes
`timescale 1ns/10ps
module host_model import frame_pkg::*; (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Byte streams
    output byte_beat_t rx_beat,
    input wire byte_beat_t tx_beat,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic pv = 1'b0;
    int cyc = 0;
    logic [7:0] got[$];
    int starts[$];
    initial rx_beat = '0;
    initial tx_ready = 1'b0;
    // One byte a cycle; idle data is inverted so a stale byte never looks valid
    task automatic send(input logic [7:0] sub, input logic [7:0] md, input logic [15:0] ln, input logic [7:0] tl);
        logic [7:0] q[$];
        q = {DLE_BYTE, MSG_ID, sub, ln[15:8], ln[7:0], md, 8'h00, DLE_BYTE, tl};
        q[6] = q[1] ^ q[2] ^ q[3] ^ q[4] ^ q[5];
        foreach (q[i]) begin
            @(posedge pclk);
            rx_beat <= {1'b1, q[i]};
        end
        @(posedge pclk);
        rx_beat <= {1'b0, ~q[8]};
    endtask : send
    // Slow mode stalls every other cycle to test byte holding
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        tx_ready <= slow ? ~tx_ready : 1'b1;
        pv <= tx_beat.valid;
        if (tx_beat.valid && !pv) starts.push_back(cyc);
        if (tx_beat.valid && tx_ready) got.push_back(tx_beat.data);
    end
endmodule : host_model

// ---- testbench/timing_report_packet_framer_bench.sv ----
// Self-checking bench for the report framer
`timescale 1ns/10ps
module timing_report_packet_framer_bench import frame_pkg::*; ();
    localparam int PER = 200;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    byte_beat_t rx_beat;
    byte_beat_t tx_beat;
    logic tx_ready;
    logic [7:0] e[$];
    int bad_count = 0;
    int checked = 0;
    always #5 pclk = ~pclk;
    report_framer #(.PERIOD_CYCLES(PER)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_beat(rx_beat), .tx_beat(tx_beat), .tx_ready(tx_ready));
    host_model host (.pclk(pclk), .presetn(presetn), .rx_beat(rx_beat), .tx_beat(tx_beat), .tx_ready(tx_ready));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
        output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic er;
        apb(1'b1, a, d, q, er);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
        logic [31:0] q;
        logic er;
        apb(1'b0, a, 32'h00000000, q, er);
        check(q, x);
        check({31'h0, er}, {31'h0, xe});
    endtask : rd
    // Expected bytes, most significant first
    task automatic put(input logic [31:0] v, input int n);
        for (int i = n - 1; i >= 0; i--) e.push_back(v[8*i +: 8]);
    endtask : put
    task automatic head(input logic [7:0] s, input logic [15:0] ln);
        put({DLE_BYTE, MSG_ID, s, ln[15:8]}, 4);
        put({16'h0, ln[7:0], MODE_RESP}, 2);
    endtask : head
    task automatic freq_exp(input logic [7:0] dac, input logic [7:0] lp, input logic [7:0] rf);
        head(SUB_FREQ, 16'h0031);
        put(32'hC1200000, 4);
        put({24'h0, dac}, 1);
        put(32'h0, 4);
        put(32'h0, 4);
        put({24'h0, lp}, 1);
        repeat (8) put(32'h0, 4);
        put({24'h0, rf}, 1);
    endtask : freq_exp
    // Append checksum and trailer, wait for the bytes, compare and drop them
    task automatic expect_frame();
        logic [7:0] c;
        int n;
        c = 8'h00;
        n = 0;
        foreach (e[i]) if (i > 0) c ^= e[i];
        put({24'h0, c}, 1);
        put({16'h0, DLE_BYTE, ETX_BYTE}, 2);
        while (host.got.size() < e.size() && n < 5000) begin
            @(posedge pclk);
            n++;
        end
        foreach (e[i]) check({24'h0, host.got[i]}, {24'h0, e[i]});
        repeat (e.size()) void'(host.got.pop_front());
        e.delete();
    endtask : expect_frame
    task automatic summarize();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : summarize
    initial begin
        #200us;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int a = 0; a <= 40; a += 4) rd(8'(a), 32'h0, 1'b0);
        rd(8'h40, 32'h0, 1'b1);
        wr(REG_VALID, 32'h0A);
        wr(REG_WEEK, 32'h1234);
        wr(REG_TIME_OF_WEEK, 32'd604800);
        rd(REG_TIME_OF_WEEK, 32'd604799, 1'b0);
        for (int i = 0; i < 4; i++) wr(8'(REG_OFS1 + 4 * i), 32'h3F800000 + i);
        wr(REG_FREQ, 32'hC1200000);
        wr(REG_OSC, 32'h00070C21);
        // Dropped: no extra constellations, bad length, bad mode, bad trailer
        host.send(SUB_CORR, 8'h00, 16'h0002, ETX_BYTE);
        host.send(SUB_FREQ, 8'h00, 16'h0003, ETX_BYTE);
        host.send(SUB_FREQ, 8'h01, 16'h0002, ETX_BYTE);
        host.send(SUB_FREQ, 8'h00, 16'h0002, 8'h04);
        repeat (30) @(posedge pclk);
        check(host.got.size(), 0);
        rd(REG_STATUS, 32'h00040000, 1'b0);
        // Both kinds back to back under a stalling host
        wr(REG_CTRL, 32'h2);
        host.slow = 1'b1;
        host.send(SUB_CORR, 8'h00, 16'h0002, ETX_BYTE);
        host.send(SUB_FREQ, 8'h00, 16'h0002, ETX_BYTE);
        head(SUB_CORR, 16'h001D);
        put(32'h0B, 1);
        put(32'h1234, 2);
        put(32'd604799, 4);
        put(32'h0, 4);
        for (int i = 0; i < 4; i++) put(32'h3F800000 + i, 4);
        expect_frame();
        freq_exp(DAC_BITS_MAX, 8'h00, 8'h07);
        expect_frame();
        // Unprompted reports, synthesis steering, locked state
        host.slow = 1'b0;
        wr(REG_OSC, 32'h00000500);
        wr(REG_CTRL, 32'h3);
        host.starts.delete();
        for (int n = 0; n < 600 && host.starts.size() == 0; n++) @(posedge pclk);
        for (int n = 0; n < 600 && tx_beat.valid !== 1'b0; n++) @(posedge pclk);
        host.got.delete();
        host.starts.delete();
        freq_exp(8'h00, 8'h05, 8'h00);
        expect_frame();
        for (int n = 0; n < 600 && host.starts.size() < 2; n++) @(posedge pclk);
        check(host.starts[1] - host.starts[0], PER);
        summarize();
    end
endmodule : timing_report_packet_framer_bench
